// file: rtl/ivr_pkg.sv
// Constants and types for the interrupt vector relocation block
package ivr_pkg;
    localparam int ADDR_W = 12;
    // Register byte offsets on the bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] VBASE_OFS = 8'h08;
    // General interrupt control field positions
    localparam int EXT_IRQ1_BIT = 7;
    localparam int EXT_IRQ0_BIT = 6;
    localparam int EXT_IRQ2_BIT = 5;
    localparam int SELECT_BIT = 1;
    localparam int UNLOCK_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] EXT_EN_RST = 3'h0;
    // Unlock window length in core cycles
    localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
    // Boot section start per boot size fuse code (word addresses)
    localparam logic [ADDR_W-1:0] BOOT_START_SZ0 = 12'hC00;
    localparam logic [ADDR_W-1:0] BOOT_START_SZ1 = 12'hE00;
    localparam logic [ADDR_W-1:0] BOOT_START_SZ2 = 12'hF00;
    localparam logic [ADDR_W-1:0] BOOT_START_SZ3 = 12'hF80;
    localparam logic [ADDR_W-1:0] APP_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] VEC_FIRST_OFS = 12'h001;
    // Fuse vector: {app lock_n, boot lock_n, boot reset_n, size[1:0]}, all unprogrammed
    localparam int FUSE_W = 5;
    localparam logic [FUSE_W-1:0] FUSE_RST = 5'h1F;
    typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_HOLD} seq_state_t;
endpackage

// file: rtl/fuse_sync.sv
// Two-stage synchroniser for the static fuse and lock inputs
module fuse_sync
    import ivr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Fuse levels
    input wire logic [FUSE_W-1:0] fuse_raw,
    output logic [FUSE_W-1:0] fuse_sync
);
    logic [FUSE_W-1:0] meta_r;
    logic [FUSE_W-1:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < FUSE_W; i++) begin : g_bit
            // Reset to the unprogrammed level so nothing is locked until real values arrive
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    meta_r[i] <= FUSE_RST[i];
                    sync_r[i] <= FUSE_RST[i];
                end else begin
                    meta_r[i] <= fuse_raw[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign fuse_sync = sync_r;
endmodule

// file: rtl/vector_reloc.sv
// Interrupt vector placement control with timed unlock and boot lock gating
// Summary of operation
// - A clear select bit puts vectors at flash start and a set one at the boot loader section start.
// - The boot section start used as relocated base comes from the boot size fuses.
// - Interrupts are blocked from the unlock cycle until after the instruction following the select write.
// - Without a select write, interrupts stay blocked for four cycles and are then released.
// - The automatic blocking never touches the processor's global interrupt enable bit.
// - Hardware clears the unlock bit four cycles after it is set or at the select write, whichever first.
// - With vectors in boot space and the application lock programmed, interrupts are off in application code.
// - With vectors in application space and the boot lock programmed, interrupts are off in boot code.
// - The control register has enables at bits 7..5, zero bits 4..2, select and unlock at 1..0, reset zero.
// - With a 2K-byte boot section and boot reset programmed, reset is at C00 and relocated vectors at C01.
// - Reset address is zero or the boot reset address by fuse, vectors start one above the base.
// - A relocated vector address is its normal table address plus the boot section start.
module vector_reloc
    import ivr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Fuse and lock pins, low when programmed
    input wire logic [1:0] boot_size_fuses,
    input wire logic boot_reset_fuse_n,
    input wire logic app_section_boot_lock_n,
    input wire logic boot_section_boot_lock_n,
    // Core side
    input wire logic [ADDR_W-1:0] exec_pc,
    input wire logic insn_done,
    input wire logic [4:0] vec_num,
    output logic irq_block,
    output logic [ADDR_W-1:0] reset_addr,
    output logic [ADDR_W-1:0] vector_base,
    output logic [ADDR_W-1:0] vec_addr,
    output logic ext_irq0_enable,
    output logic ext_irq1_enable,
    output logic ext_irq2_enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Fuses
    logic [FUSE_W-1:0] fuse_s;
    fuse_sync u_fuse_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .fuse_raw({app_section_boot_lock_n, boot_section_boot_lock_n, boot_reset_fuse_n, boot_size_fuses}),
        .fuse_sync(fuse_s)
    );
    wire [1:0] size_s = fuse_s[1:0];
    wire boot_reset_n_s = fuse_s[2];
    wire boot_lock_n_s = fuse_s[3];
    wire app_lock_n_s = fuse_s[4];

    wire [ADDR_W-1:0] boot_start = (size_s == 2'h0) ? BOOT_START_SZ0 :
                                   (size_s == 2'h1) ? BOOT_START_SZ1 :
                                   (size_s == 2'h2) ? BOOT_START_SZ2 : BOOT_START_SZ3;

    // Bus decode
    logic ack_r;
    logic err_r;
    logic [31:0] rdat_r;
    wire req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    wire hit_ctrl = wb_adr_i == CTRL_OFS;
    wire hit_stat = wb_adr_i == STAT_OFS;
    wire hit_vbase = wb_adr_i == VBASE_OFS;
    wire mapped = hit_ctrl || hit_stat || hit_vbase;
    wire ctrl_wr = req && wb_we_i && hit_ctrl && wb_sel_i[0];
    wire [7:0] wdat = wb_dat_i[7:0];
    wire set_unlock = ctrl_wr && wdat[UNLOCK_BIT];

    // Control state
    logic vsel_r;
    logic unlock_r;
    logic [2:0] cnt_r;
    logic [2:0] ext_en_r;
    seq_state_t state_r;
    seq_state_t state_nxt;

    // Select is taken only by a write with unlock zero inside the open window
    wire sel_write = ctrl_wr && !wdat[UNLOCK_BIT] && unlock_r;
    wire window_end = unlock_r && (cnt_r == 3'h1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (set_unlock) state_nxt = ST_OPEN;
            end
            ST_OPEN: begin
                if (set_unlock) state_nxt = ST_OPEN;
                else if (sel_write) state_nxt = ST_HOLD;
                else if (window_end) state_nxt = ST_IDLE;
            end
            ST_HOLD: begin
                if (set_unlock) state_nxt = ST_OPEN;
                else if (insn_done) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Unlock bit and its countdown; a new set beats the timeout clear
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            unlock_r <= 1'b0;
            cnt_r <= 3'h0;
        end else if (set_unlock) begin
            unlock_r <= 1'b1;
            cnt_r <= UNLOCK_WINDOW_CYC;
        end else if (sel_write || window_end) begin
            unlock_r <= 1'b0;
            cnt_r <= 3'h0;
        end else if (unlock_r) begin
            cnt_r <= cnt_r - 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            vsel_r <= 1'b0;
            ext_en_r <= EXT_EN_RST;
        end else begin
            if (ctrl_wr) ext_en_r <= {wdat[EXT_IRQ1_BIT], wdat[EXT_IRQ0_BIT], wdat[EXT_IRQ2_BIT]};
            if (sel_write) vsel_r <= wdat[SELECT_BIT];
        end
    end

    // Section gating; the processor's own enable flag is never driven from here
    wire pc_in_boot = exec_pc >= boot_start;
    wire lock_block = (vsel_r && !app_lock_n_s && !pc_in_boot) ||
                      (!vsel_r && !boot_lock_n_s && pc_in_boot);
    wire block_nxt = (state_nxt != ST_IDLE) || lock_block;

    wire [ADDR_W-1:0] base_nxt = vsel_r ? boot_start : APP_BASE;
    wire [ADDR_W-1:0] reset_nxt = boot_reset_n_s ? APP_BASE : boot_start;
    wire [ADDR_W-1:0] vaddr_nxt = base_nxt + {7'h00, vec_num};

    logic block_r;
    logic [ADDR_W-1:0] base_r;
    logic [ADDR_W-1:0] reset_r;
    logic [ADDR_W-1:0] vaddr_r;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            block_r <= 1'b0;
            base_r <= APP_BASE;
            reset_r <= APP_BASE;
            vaddr_r <= APP_BASE;
        end else begin
            block_r <= block_nxt;
            base_r <= base_nxt;
            reset_r <= reset_nxt;
            vaddr_r <= vaddr_nxt;
        end
    end

    // Read data
    wire [7:0] ctrl_val = {ext_en_r[2], ext_en_r[1], ext_en_r[0], 3'h0, vsel_r, unlock_r};
    wire [7:0] stat_val = {2'h0, size_s, !boot_reset_n_s, lock_block, state_r != ST_IDLE, block_r};
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_val} :
                         hit_stat ? {24'h000000, stat_val} :
                         hit_vbase ? {20'h00000, base_r} : 32'h00000000;

    // Single-wait answer: ack or err the cycle after the strobe, then dropped
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ack_r <= req && mapped;
            err_r <= req && !mapped;
            rdat_r <= (req && !wb_we_i) ? rd_mux : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdat_r;
    assign irq_block = block_r;
    assign vector_base = base_r;
    assign reset_addr = reset_r;
    assign vec_addr = vaddr_r;
    assign ext_irq1_enable = ext_en_r[2];
    assign ext_irq0_enable = ext_en_r[1];
    assign ext_irq2_enable = ext_en_r[0];

    // Unlock sequence
    a_unlock_four_cycles: assert property (set_unlock ##1 (!ctrl_wr)[*4] |=> !unlock_r)
        else $error("unlock bit not cleared after four cycles");

    a_timeout_release: assert property (set_unlock ##1 (!ctrl_wr)[*4] |=> state_r == ST_IDLE)
        else $error("sequence block not released after four cycles");

    a_block_from_unlock: assert property (set_unlock |=> irq_block && unlock_r)
        else $error("interrupts not blocked in the unlock cycle");

    a_select_takes: assert property (sel_write |=> vsel_r == $past(wdat[SELECT_BIT]) && !unlock_r && irq_block)
        else $error("select write in window not taken");

    a_hold_release: assert property (state_r == ST_HOLD && insn_done && !set_unlock |=> state_r == ST_IDLE)
        else $error("block not released after following instruction");

    a_select_locked: assert property (ctrl_wr && !unlock_r |=> $stable(vsel_r))
        else $error("select changed without unlock");

    a_unlock_set: assert property (set_unlock |=> unlock_r && cnt_r == UNLOCK_WINDOW_CYC)
        else $error("unlock window not started");

    a_unlock_clear_sel: assert property (sel_write |=> !unlock_r)
        else $error("unlock bit kept after select write");

    a_unlock_count: assert property (unlock_r |-> cnt_r != 3'h0)
        else $error("unlock bit set with empty window");

    a_unlock_bound: assert property (unlock_r && !ctrl_wr && cnt_r == 3'h1 |=> !unlock_r)
        else $error("unlock bit outlived its window");

    a_count_down: assert property (unlock_r && !ctrl_wr && cnt_r != 3'h1 |=> cnt_r == $past(cnt_r) - 3'h1)
        else $error("unlock window did not count down");

    a_open_is_unlock: assert property (state_r == ST_OPEN |-> unlock_r)
        else $error("open state without unlock bit");

    a_unlock_is_open: assert property (unlock_r |-> state_r == ST_OPEN)
        else $error("unlock bit outside open state");

    a_hold_after_sel: assert property (sel_write |=> state_r == ST_HOLD)
        else $error("select write did not enter hold");

    a_hold_keeps: assert property (state_r == ST_HOLD && !insn_done |=> irq_block)
        else $error("block dropped before following instruction");

    a_seq_blocks: assert property (state_r != ST_IDLE |-> irq_block)
        else $error("sequence active with interrupts open");

    a_timeout_idle: assert property (unlock_r && cnt_r == 3'h1 && !ctrl_wr |=> state_r == ST_IDLE)
        else $error("sequence not idle after timeout");

    a_release_clean: assert property (state_nxt == ST_IDLE && !lock_block |=> !irq_block)
        else $error("block held with no cause");

    // Boot lock gating
    a_app_lock_gate: assert property (vsel_r && !app_lock_n_s && exec_pc < boot_start |=> irq_block)
        else $error("interrupts open in application code under lock");

    a_app_lock_boot_pc: assert property (vsel_r && !app_lock_n_s && boot_lock_n_s && pc_in_boot && state_nxt == ST_IDLE |=> !irq_block)
        else $error("boot code blocked by application lock");

    a_boot_lock_gate: assert property (!vsel_r && !boot_lock_n_s && exec_pc >= boot_start |=> irq_block)
        else $error("interrupts open in boot code under lock");

    a_gate_needs_lock: assert property (app_lock_n_s && boot_lock_n_s && state_nxt == ST_IDLE |=> !irq_block)
        else $error("interrupts blocked with no lock programmed");

    // Register bus
    a_reserved_zero: assert property (req && !wb_we_i && hit_ctrl |=> wb_ack_o && wb_dat_o[4:2] == 3'h0)
        else $error("reserved control bits read nonzero");

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_follows_req: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged");

    a_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");

    a_no_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");

    a_dat_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");

    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:12] == 20'h00000)
        else $error("upper read bits nonzero");

    a_write_no_data: assert property (req && wb_we_i |=> wb_dat_o == 32'h00000000)
        else $error("write returned data");

    a_ctrl_read: assert property (req && !wb_we_i && hit_ctrl |=> wb_dat_o[1:0] == {$past(vsel_r), $past(unlock_r)})
        else $error("select or unlock read wrong");

    a_enable_write: assert property (ctrl_wr |=> {ext_irq1_enable, ext_irq0_enable, ext_irq2_enable} == $past(wdat[7:5]))
        else $error("interrupt enables not written");

    a_enable_hold: assert property (!ctrl_wr |=> $stable({ext_irq1_enable, ext_irq0_enable, ext_irq2_enable}))
        else $error("interrupt enables changed without write");

    a_sel_lane: assert property (req && wb_we_i && hit_ctrl && !wb_sel_i[0] |=> $stable(vsel_r) && $stable(ext_en_r))
        else $error("write without low lane changed control");

    a_err_no_effect: assert property (req && !mapped |=> $stable(vsel_r) && $stable(ext_en_r))
        else $error("refused access changed control");

    a_status_block: assert property (req && !wb_we_i && hit_stat |=> wb_dat_o[0] == $past(irq_block))
        else $error("status block bit wrong");

    a_vbase_read: assert property (req && !wb_we_i && hit_vbase |=> wb_dat_o[11:0] == $past(vector_base))
        else $error("vector base read wrong");

    // Addresses
    a_boot_2k_reset: assert property (!boot_reset_n_s && size_s == 2'h0 ##1 $stable(fuse_s) |-> reset_addr == 12'hC00)
        else $error("boot reset address wrong for 2K section");

    a_boot_2k_vec: assert property (vsel_r && size_s == 2'h0 && vec_num == 5'h01 |=> vec_addr == 12'hC01)
        else $error("first relocated vector wrong for 2K section");

    a_app_first_vec: assert property (!vsel_r && vec_num == 5'h01 |=> vec_addr == VEC_FIRST_OFS)
        else $error("first vector wrong in application space");

    a_reset_app: assert property (boot_reset_n_s |=> reset_addr == APP_BASE)
        else $error("reset address not flash start");

    a_reset_boot: assert property (!boot_reset_n_s |=> reset_addr == $past(boot_start))
        else $error("reset address not boot start");

    a_vector_base_app: assert property (!vsel_r |=> vector_base == APP_BASE)
        else $error("vector base not flash start");

    a_vector_base_boot: assert property (vsel_r |=> vector_base == $past(boot_start))
        else $error("vector base not boot start");

    a_base_select: assert property ($stable(vsel_r) && $stable(fuse_s) |=> vector_base == ($past(vsel_r) ? $past(boot_start) : APP_BASE))
        else $error("vector base does not follow select");

    a_vector_offset: assert property ($stable(vsel_r) && $stable(fuse_s) |=> vec_addr == vector_base + {7'h00, $past(vec_num)})
        else $error("vector address not base plus index");
endmodule

// file: sim/vector_reloc_tb_top.sv
// Self-checking bench for the interrupt vector relocation block
module vector_reloc_tb_top
    import ivr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, insn_done = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, wb_err_o, irq_block, ext_irq0_enable, ext_irq1_enable, ext_irq2_enable, er;
    logic [1:0] boot_size_fuses = 2'h0;
    logic boot_reset_fuse_n = 1'b1, app_section_boot_lock_n = 1'b1, boot_section_boot_lock_n = 1'b1;
    logic [ADDR_W-1:0] exec_pc = 12'h000;
    logic [4:0] vec_num = 5'h00;
    logic [ADDR_W-1:0] reset_addr, vector_base, vec_addr, bs;
    logic [ADDR_W-1:0] boot_tab [4] = '{BOOT_START_SZ0, BOOT_START_SZ1, BOOT_START_SZ2, BOOT_START_SZ3};
    int mismatches = 0, total_checks = 0, seed = 32'h83B3;
    // Reference model of the control register
    logic [2:0] en_m = 3'h0;
    logic sel_m = 1'b0, unl_m = 1'b0;

    vector_reloc u_dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .boot_size_fuses(boot_size_fuses),
        .boot_reset_fuse_n(boot_reset_fuse_n), .app_section_boot_lock_n(app_section_boot_lock_n),
        .boot_section_boot_lock_n(boot_section_boot_lock_n), .exec_pc(exec_pc), .insn_done(insn_done),
        .vec_num(vec_num), .irq_block(irq_block), .reset_addr(reset_addr), .vector_base(vector_base),
        .vec_addr(vec_addr), .ext_irq0_enable(ext_irq0_enable), .ext_irq1_enable(ext_irq1_enable),
        .ext_irq2_enable(ext_irq2_enable));

    always #12.5 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Entered at a rising edge; the trailing edge keeps the strobe low for a full cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic gw(input logic [7:0] d);
        logic open;
        open = unl_m;
        wb_xfer(1'b1, CTRL_OFS, d);
        en_m = d[7:5];
        if (open && !d[0]) sel_m = d[1];
        unl_m = d[0];
    endtask

    task automatic gr_check();
        wb_xfer(1'b0, CTRL_OFS, 8'h00);
        check(rd, {24'h0, en_m, 3'h0, sel_m, unl_m});
        check({29'h0, ext_irq1_enable, ext_irq0_enable, ext_irq2_enable}, {29'h0, en_m});
    endtask

    // Second write lands two cycles after the unlock ack, inside the four-cycle window
    task automatic relocate(input logic s);
        gw({en_m, 4'h0, 1'b1});
        check({31'h0, irq_block}, 32'h1);
        gw({en_m, 3'h0, s, 1'b0});
        check({31'h0, irq_block}, 32'h1);
        insn_done <= 1'b1;
        @(posedge core_clk);
        insn_done <= 1'b0;
        @(posedge core_clk);
        check({31'h0, irq_block}, 32'h0);
        check({20'h0, vector_base}, {20'h0, s ? bs : APP_BASE});
        gr_check();
    endtask

    initial begin
        #(25 * 4000);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        gr_check();
        wb_xfer(1'b0, 8'h0C, 8'h00);
        check({31'h0, er}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            gw($random(seed) & 8'hFE);
            gr_check();
            check({20'h0, vector_base}, 32'h0);
        end
        for (int sz = 0; sz < 4; sz++) begin
            boot_size_fuses <= sz[1:0];
            boot_reset_fuse_n <= sz[0];
            repeat (5) @(posedge core_clk);
            bs = (sz == 0) ? 12'hC00 : boot_tab[sz];
            check({20'h0, reset_addr}, {20'h0, sz[0] ? APP_BASE : bs});
            relocate(1'b1);
            for (int v = 0; v < 3; v++) begin
                vec_num <= (v == 0) ? 5'h01 : 5'($random(seed));
                repeat (2) @(posedge core_clk);
                check({20'h0, vec_addr}, {20'h0, bs + 12'(vec_num)});
            end
            relocate(1'b0);
        end
        gw({en_m, 4'h2, 1'b1});
        check({31'h0, irq_block}, 32'h1);
        repeat (2) begin
            @(posedge core_clk);
            check({31'h0, irq_block}, 32'h1);
        end
        @(posedge core_clk);
        check({31'h0, irq_block}, 32'h0);
        unl_m = 1'b0;
        gr_check();
        boot_section_boot_lock_n <= 1'b0;
        exec_pc <= bs + 12'($random(seed) & 32'h7F);
        repeat (5) @(posedge core_clk);
        check({31'h0, irq_block}, 32'h1);
        exec_pc <= bs - 12'h001 - 12'($random(seed) & 32'hFF);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq_block}, 32'h0);
        boot_section_boot_lock_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        relocate(1'b1);
        app_section_boot_lock_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        check({31'h0, irq_block}, 32'h1);
        exec_pc <= bs + 12'h010;
        repeat (3) @(posedge core_clk);
        check({31'h0, irq_block}, 32'h0);
        report_and_stop();
    end
endmodule
